// ==== logic/sac_pkg.sv ====
// What this block does
// - Chip select high: data output floats, shift clock edges are ignored.
// - Chip select fall accepted after two rising, one falling system clock edge.
// - Chip select rise floats the data output within the output disable time.
// - Selecting shows the previous result's most significant bit before any shift edge.
// - First four shift clock falls drive previous result bits two to five.
// - Sampling starts after the fourth shift clock fall and lasts until the eighth fall.
// - Next three shift clock falls drive bits six, seven and eight.
// - Eighth fall starts four hold cycles, then thirty-two conversion cycles.
// - Chip select stays high until conversion ends; an early valid fall aborts.
// - A new complete frame during conversion aborts it and restarts conversion.
// - Each conversion finishes within seventeen microseconds from the hold instant.
// - Full access and conversion repeats every 22 or 25 microseconds.
// - Hold and conversion run on the system clock, independent of shift clock.
// - Results are straight binary: zero scale all zeros, full scale all ones.
package sac_pkg;

	// ----------------------------------------------------------------
	// Widths and sequence counts
	// ----------------------------------------------------------------
	localparam int RES_W = 8;
	localparam int FIFO_DEPTH = 4;
	localparam int SAMPLE_FALL = 4;
	localparam int FRAME_FALLS = 8;
	localparam int HOLD_CYC = 4;
	localparam int CONV_CYC = 32;
	localparam int TOTAL_CYC = HOLD_CYC + CONV_CYC;
	localparam logic [7:0] RESULT_RST = 8'h00;

	// ----------------------------------------------------------------
	// Timing, system clock at 25 ns
	// ----------------------------------------------------------------
	localparam int MCLK_PERIOD_NS = 25;
	localparam int OUTPUT_DISABLE_TIME_NS = 150;
	localparam int OUTPUT_DISABLE_CYC = (OUTPUT_DISABLE_TIME_NS / MCLK_PERIOD_NS < 1) ? 1 :
		OUTPUT_DISABLE_TIME_NS / MCLK_PERIOD_NS;
	localparam int CONV_TIME_MAX_US = 17;
	localparam int CONV_TIME_MAX_CYC = (CONV_TIME_MAX_US * 1000) / MCLK_PERIOD_NS;
	// Whole access plus conversion period of the two speed grades
	localparam int CYCLE_FAST_US = 22;
	localparam int CYCLE_SLOW_US = 25;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [RES_W-1:0] code;
	} sac_result_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HOLD = 2'b01,
		ST_CONV = 2'b10,
		ST_DONE = 2'b11
	} sac_state_t;

	// One successive-approximation decision on the held code
	function automatic logic [7:0] sac_sar_step(
		input logic [7:0] approx,
		input logic [7:0] held,
		input logic [2:0] bpos
	);
		logic [7:0] trial;
		trial = approx | (8'h01 << bpos);
		return (trial <= held) ? trial : approx;
	endfunction

endpackage

// ==== logic/sac_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none
module sac_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic do_wr;
	logic do_rd;

	// ----------------------------------------------------------------
	// Flags: pointers carry one extra bit so full and empty differ
	// ----------------------------------------------------------------
	assign in_ready = (wr_q - rd_q) != (AW + 1)'(DEPTH);
	assign out_valid = wr_q != rd_q;
	assign out_data = mem[rd_q[AW-1:0]];
	assign do_wr = in_valid & in_ready;
	assign do_rd = out_valid & out_ready;

	// Pointer update
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_q <= '0;
			rd_q <= '0;
		end
		else
		begin
			if (do_wr)
				wr_q <= wr_q + 1'b1;
			if (do_rd)
				rd_q <= rd_q + 1'b1;
		end
	end

	// Storage needs no reset; empty flag hides stale words
	always_ff @(posedge clk)
	begin
		if (do_wr)
			mem[wr_q[AW-1:0]] <= in_data;
	end

endmodule
`default_nettype wire

// ==== logic/sac_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module sac_top (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic io_clk,
	input wire logic cs_n,
	input wire logic [7:0] ain_code,
	output logic sdo,
	output logic sdo_oe,
	output logic sample_on,
	output logic hold_on,
	output logic conv_busy
);
	localparam int DIS_MAX = sac_pkg::OUTPUT_DISABLE_CYC;

	// ----------------------------------------------------------------
	// Link domain: one toggle per shift clock falling edge
	// ----------------------------------------------------------------
	logic edge_tog_q;

	// Only a toggle crosses, so the shift clock may stop at any time
	always_ff @(negedge io_clk or negedge arst_n)
	begin
		if (!arst_n)
			edge_tog_q <= 1'b0;
		else
			edge_tog_q <= ~edge_tog_q;
	end

	// ----------------------------------------------------------------
	// Chip select and edge synchronisers
	// ----------------------------------------------------------------
	logic cs_s1_q;
	logic cs_s2_q;
	logic cs_neg_q;
	logic sel_q;
	logic tg_s1_q;
	logic tg_s2_q;
	logic tg_s3_q;

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			tg_s1_q <= 1'b0;
			tg_s2_q <= 1'b0;
			tg_s3_q <= 1'b0;
		end
		else
		begin
			cs_s1_q <= cs_n;
			cs_s2_q <= cs_s1_q;
			tg_s1_q <= edge_tog_q;
			tg_s2_q <= tg_s1_q;
			tg_s3_q <= tg_s2_q;
		end
	end

	// Falling-edge stage completes the two-rise-one-fall noise filter
	always_ff @(negedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			cs_neg_q <= 1'b1;
		else
			cs_neg_q <= cs_s2_q;
	end

	// ----------------------------------------------------------------
	// Select decode
	// ----------------------------------------------------------------
	logic sel_d;
	logic accept;
	logic fall_evt;
	logic fall_ok;
	logic fall8;

	// Deselect acts on the second flop alone: fast release of the pin
	assign sel_d = ~cs_s2_q & ~cs_neg_q;
	assign accept = sel_d & ~sel_q;
	assign fall_evt = tg_s2_q ^ tg_s3_q;
	assign fall_ok = fall_evt & sel_q;

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			sel_q <= 1'b0;
		else
			sel_q <= sel_d;
	end

	// ----------------------------------------------------------------
	// Frame bit counter and shifter
	// ----------------------------------------------------------------
	logic [2:0] cnt_q;
	logic [7:0] shift_q;
	logic sdo_q;
	logic samp_q;
	logic [7:0] out_q;
	logic [7:0] load_val;
	logic load;
	logic drain_rdy;
	logic pop;
	logic pop_valid;
	sac_pkg::sac_result_t pop_data;

	assign fall8 = fall_ok & (cnt_q == 3'(sac_pkg::FRAME_FALLS - 1));
	// New results enter only between frames so a word is never torn
	assign drain_rdy = ~sel_q | ((cnt_q == 3'h0) & ~fall_evt);
	assign pop = pop_valid & drain_rdy;
	assign load_val = pop ? pop_data.code : out_q;
	assign load = accept | fall8 | (pop & sel_q);

	// A wrap from seven back to zero lets frames follow with select held low
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			cnt_q <= 3'h0;
		else if (accept)
			cnt_q <= 3'h0;
		else if (fall_ok)
			cnt_q <= cnt_q + 3'h1;
	end

	// Shifter: previous result, most significant bit first
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			shift_q <= sac_pkg::RESULT_RST;
			sdo_q <= 1'b0;
		end
		else if (load)
		begin
			shift_q <= load_val;
			sdo_q <= load_val[7];
		end
		else if (fall_ok)
		begin
			shift_q <= {shift_q[6:0], 1'b0};
			sdo_q <= shift_q[6];
		end
	end

	// Sampling window from the fourth fall up to the eighth
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			samp_q <= 1'b0;
		else if (fall8 | accept)
			samp_q <= 1'b0;
		else if (fall_ok & (cnt_q == 3'(sac_pkg::SAMPLE_FALL - 1)))
			samp_q <= 1'b1;
	end

	// Output data register changes only through the result queue
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			out_q <= sac_pkg::RESULT_RST;
		else if (pop)
			out_q <= pop_data.code;
	end

	// ----------------------------------------------------------------
	// Hold and conversion on the system clock
	// ----------------------------------------------------------------
	sac_pkg::sac_state_t st_q;
	sac_pkg::sac_state_t st_d;
	logic [5:0] tmr_q;
	logic [5:0] tmr_d;
	logic [7:0] held_q;
	logic [7:0] approx_q;
	logic [7:0] dec;
	logic conv_last;
	logic hold_last;
	logic push_v;
	logic push_rdy;
	logic abort;
	sac_pkg::sac_result_t push_data;

	assign abort = accept & (st_q != sac_pkg::ST_IDLE);
	assign hold_last = (st_q == sac_pkg::ST_HOLD) & (tmr_q == 6'(sac_pkg::HOLD_CYC - 1));
	assign conv_last = (st_q == sac_pkg::ST_CONV) & (tmr_q == 6'(sac_pkg::CONV_CYC - 1));
	// Four system cycles per bit; decide on the last cycle of each
	assign dec = sac_pkg::sac_sar_step(approx_q, held_q, 3'h7 - tmr_q[4:2]);
	assign push_v = conv_last | (st_q == sac_pkg::ST_DONE);
	assign push_data.code = (st_q == sac_pkg::ST_DONE) ? approx_q : dec;

	// Next state; a new frame outranks an abort, both outrank progress
	always_comb
	begin
		st_d = st_q;
		tmr_d = tmr_q + 6'h01;
		if (fall8)
		begin
			st_d = sac_pkg::ST_HOLD;
			tmr_d = 6'h00;
		end
		else if (abort)
		begin
			st_d = sac_pkg::ST_IDLE;
			tmr_d = 6'h00;
		end
		else
		begin
			unique case (st_q)
				sac_pkg::ST_IDLE:
				begin
					tmr_d = 6'h00;
				end
				sac_pkg::ST_HOLD:
				begin
					if (hold_last)
					begin
						st_d = sac_pkg::ST_CONV;
						tmr_d = 6'h00;
					end
				end
				sac_pkg::ST_CONV:
				begin
					if (conv_last)
						st_d = push_rdy ? sac_pkg::ST_IDLE : sac_pkg::ST_DONE;
				end
				sac_pkg::ST_DONE:
				begin
					tmr_d = 6'h00;
					if (push_rdy)
						st_d = sac_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_q <= sac_pkg::ST_IDLE;
			tmr_q <= 6'h00;
		end
		else
		begin
			st_q <= st_d;
			tmr_q <= tmr_d;
		end
	end

	// Held code is caught at the hold instant; approximation builds on it
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			held_q <= 8'h00;
			approx_q <= 8'h00;
		end
		else if (fall8)
		begin
			held_q <= ain_code;
			approx_q <= 8'h00;
		end
		else if ((st_q == sac_pkg::ST_CONV) & (tmr_q[1:0] == 2'h3))
			approx_q <= dec;
	end

	// ----------------------------------------------------------------
	// Result queue: a full queue stalls the converter in its done state
	// ----------------------------------------------------------------
	sac_fifo #(
		.W($bits(sac_pkg::sac_result_t)),
		.DEPTH(sac_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(mclk),
		.arst_n(arst_n),
		.in_valid(push_v),
		.in_ready(push_rdy),
		.in_data(push_data),
		.out_valid(pop_valid),
		.out_ready(drain_rdy),
		.out_data(pop_data)
	);

	// ----------------------------------------------------------------
	// Outputs, all registered
	// ----------------------------------------------------------------
	logic hold_q;
	logic busy_q;

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hold_q <= 1'b0;
			busy_q <= 1'b0;
		end
		else
		begin
			hold_q <= (st_d == sac_pkg::ST_HOLD);
			busy_q <= (st_d != sac_pkg::ST_IDLE);
		end
	end

	assign sdo = sdo_q;
	assign sdo_oe = sel_q;
	assign sample_on = samp_q;
	assign hold_on = hold_q;
	assign conv_busy = busy_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [9:0] age_q;

	// Cycles since the last hold instant, saturating
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			age_q <= 10'h000;
		else if (fall8)
			age_q <= 10'h000;
		else if (age_q != 10'h3FF)
			age_q <= age_q + 10'h001;
	end

	property p_float_deselect;
		@(posedge mclk) disable iff (!arst_n)
		$rose(cs_n) |-> ##[1:DIS_MAX] !sdo_oe;
	endproperty
	a_float_deselect: assert property (p_float_deselect) else $error("data output not floated in time");

	property p_ignore_idle;
		@(posedge mclk) disable iff (!arst_n)
		(!sel_q && !sel_d) |=> ($stable(cnt_q) && !sdo_oe && !sample_on);
	endproperty
	a_ignore_idle: assert property (p_ignore_idle) else $error("shift clock acted while deselected");

	property p_accept_filter;
		@(posedge mclk) disable iff (!arst_n)
		$rose(sdo_oe) |-> $past(!cs_s1_q, 2) && $past(!cs_s2_q) && $past(!cs_neg_q);
	endproperty
	a_accept_filter: assert property (p_accept_filter) else $error("select accepted without filtering");

	property p_msb_first;
		@(posedge mclk) disable iff (!arst_n)
		$rose(sdo_oe) |-> (sdo == out_q[7]) && (shift_q == out_q);
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("first bit is not the previous msb");

	property p_bit_shift;
		@(posedge mclk) disable iff (!arst_n)
		(fall_ok && cnt_q != 3'h7 && !accept) |=> (sdo == $past(shift_q[6]));
	endproperty
	a_bit_shift: assert property (p_bit_shift) else $error("wrong bit after shift clock fall");

	property p_sample_start;
		@(posedge mclk) disable iff (!arst_n)
		(fall_ok && cnt_q == 3'h3 && !accept) |=> sample_on ##1 (sample_on || fall_ok || !sel_q);
	endproperty
	a_sample_start: assert property (p_sample_start) else $error("sampling did not start on fourth fall");

	property p_hold_len;
		@(posedge mclk) disable iff (!arst_n || fall8 || abort)
		$rose(hold_on) |-> (hold_on && !sample_on)[*4] ##1 !hold_on;
	endproperty
	a_hold_len: assert property (p_hold_len) else $error("hold phase not four cycles");

	property p_total_len;
		@(posedge mclk) disable iff (!arst_n)
		conv_last |-> (age_q == 10'(sac_pkg::TOTAL_CYC - 1));
	endproperty
	a_total_len: assert property (p_total_len) else $error("conversion length not thirty-six cycles");

	property p_conv_max;
		@(posedge mclk) disable iff (!arst_n)
		(st_q == sac_pkg::ST_CONV) |-> (age_q < 10'(sac_pkg::CONV_TIME_MAX_CYC));
	endproperty
	a_conv_max: assert property (p_conv_max) else $error("conversion exceeds time limit");

	property p_restart;
		@(posedge mclk) disable iff (!arst_n)
		(fall8 && conv_busy) |=> hold_on && conv_busy && (held_q == $past(ain_code));
	endproperty
	a_restart: assert property (p_restart) else $error("new frame did not restart conversion");

	property p_abort;
		@(posedge mclk) disable iff (!arst_n)
		(abort && !fall8) |=> !conv_busy ##1 !push_v;
	endproperty
	a_abort: assert property (p_abort) else $error("select fall did not abort conversion");

	property p_out_stable;
		@(posedge mclk) disable iff (!arst_n)
		!pop |=> $stable(out_q);
	endproperty
	a_out_stable: assert property (p_out_stable) else $error("output register changed without result");

endmodule
`default_nettype wire

// ==== sim/sac_ctrl_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// --------------------------------------------------------
// Controller model: chip select and shift clock master
// --------------------------------------------------------
module sac_ctrl_model (
	output logic cs_n,
	output logic io_clk,
	input wire logic sdo_line,
	output logic [7:0] falls
);
	// Idle: deselected, shift clock parked low, no free-running clock
	initial
	begin
		cs_n = 1'b1;
		io_clk = 1'b0;
		falls = 8'h00;
	end

	// Chip select fall; the fall counter restarts with each frame group
	task automatic select();
		cs_n = 1'b0;
		falls = 8'h00;
	endtask

	task automatic deselect();
		cs_n = 1'b1;
	endtask

	// Eight clean pulses of 32 ns high; gap is the low time before each rise.
	// Each bit is read just before the fall that replaces it, since the device
	// needs up to three system cycles to show a bit; 68 ns is the shortest gap used.
	task automatic frame(input int gap, output logic [7:0] got);
		for (int i = 1; i <= 8; i++)
		begin
			#(gap);
			io_clk = 1'b1;
			#32;
			got[8-i] = sdo_line;
			io_clk = 1'b0;
			falls = falls + 8'h01;
		end
		// Clock stays low afterwards until the caller starts another frame
	endtask
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam int LIMIT = 20000;
	logic mclk;
	logic arst_n;
	logic cs_n;
	logic io_clk;
	logic sdo;
	logic sdo_oe;
	logic sample_on;
	logic hold_on;
	logic conv_busy;
	logic fast;
	logic [7:0] ain_code;
	logic [7:0] falls;
	wire logic sdo_line;
	int errors;
	int check_count;
	int cyc;
	int hold_cnt;
	int busy_cnt;

	// --------------------------------------------------------
	// Design, controller and wire resolution
	// --------------------------------------------------------
	assign sdo_line = sdo_oe ? sdo : 1'bz;

	sac_top i_dut (
		.mclk(mclk),
		.arst_n(arst_n),
		.io_clk(io_clk),
		.cs_n(cs_n),
		.ain_code(ain_code),
		.sdo(sdo),
		.sdo_oe(sdo_oe),
		.sample_on(sample_on),
		.hold_on(hold_on),
		.conv_busy(conv_busy)
	);

	sac_ctrl_model i_ctrl (
		.cs_n(cs_n),
		.io_clk(io_clk),
		.sdo_line(sdo_line),
		.falls(falls)
	);

	always #12.5 mclk = ~mclk;

	// Phase length counters and hang guard
	always @(posedge mclk)
	begin
		cyc++;
		if (hold_on === 1'b1)
			hold_cnt++;
		if (conv_busy === 1'b1)
			busy_cnt++;
		if (cyc == LIMIT)
		begin
			errors++;
			close_out();
		end
	end

	// Phase starts against the fall count; fast frames may overlap the next fall
	always @(posedge sample_on)
		if (!fast)
			chk({5'h00, falls[2:0]}, 8'h04);
	always @(posedge hold_on)
		chk({5'h00, falls[2:0]}, 8'h00);

	// --------------------------------------------------------
	// Helpers
	// --------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(negedge mclk);
	endtask

	// One slow read frame, deselect, then let the conversion finish
	task automatic do_frame(input logic [7:0] code, input logic [7:0] prev);
		logic [7:0] got;
		@(negedge mclk);
		ain_code = code;
		i_ctrl.select();
		#45;
		chk({7'h00, sdo_oe}, 8'h00);
		#1355;
		chk({7'h00, sdo_oe}, 8'h01);
		hold_cnt = 0;
		busy_cnt = 0;
		i_ctrl.frame(250, got);
		chk(got, prev);
		i_ctrl.deselect();
		#150;
		chk({7'h00, sdo_oe}, 8'h00);
		wait_clk(45);
		chk(8'(hold_cnt), 8'h04);
		chk(8'(busy_cnt), 8'h24);
	endtask

	// --------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------
	// Shift clock pulses while deselected must change nothing
	task automatic t_idle();
		logic [7:0] got;
		i_ctrl.frame(100, got);
		wait_clk(4);
		chk({5'h00, sdo_oe, sample_on, conv_busy}, 8'h00);
	endtask

	// Scale ends and alternating patterns, each read one frame later
	task automatic t_codes();
		do_frame(8'hFF, 8'h00);
		do_frame(8'h00, 8'hFF);
		do_frame(8'hA5, 8'h00);
		do_frame(8'h5A, 8'hA5);
	endtask

	// Early reselect kills the running conversion; its code never shows
	task automatic t_abort();
		logic [7:0] got;
		@(negedge mclk);
		ain_code = 8'h3C;
		i_ctrl.select();
		#1400;
		i_ctrl.frame(250, got);
		chk(got, 8'h5A);
		i_ctrl.deselect();
		wait_clk(10);
		do_frame(8'h77, 8'h5A);
		do_frame(8'h44, 8'h77);
	endtask

	// Second frame with select held low lands inside the first conversion
	task automatic t_restart();
		logic [7:0] got;
		@(negedge mclk);
		ain_code = 8'h91;
		i_ctrl.select();
		#1400;
		i_ctrl.frame(250, got);
		chk(got, 8'h44);
		fast = 1'b1;
		fork
			begin
				wait_clk(4);
				ain_code = 8'h22;
			end
		join_none
		i_ctrl.frame(68, got);
		chk(got, 8'h44);
		i_ctrl.deselect();
		wait_clk(45);
		fast = 1'b0;
		do_frame(8'h00, 8'h22);
	endtask

	initial
	begin
		mclk = 1'b0;
		arst_n = 1'b0;
		ain_code = 8'h00;
		fast = 1'b0;
		errors = 0;
		check_count = 0;
		cyc = 0;
		hold_cnt = 0;
		busy_cnt = 0;
		wait_clk(3);
		arst_n = 1'b1;
		wait_clk(2);
		t_idle();
		t_codes();
		t_abort();
		t_restart();
		close_out();
	end
endmodule
`default_nettype wire
